// >>> hw/power_seq_map.vh
// Register map, field positions, reset values and state codes of the sequencer
`ifndef POWER_SEQ_MAP_VH
`define POWER_SEQ_MAP_VH

// ==========================================================
// Register offsets
`define OFS_GENERAL_CONTROL 8'h00
`define OFS_WAKE_TIME_LOW 8'h04
`define OFS_WAKE_TIME_HIGH 8'h08
`define OFS_DORMANT_SETTINGS 8'h0C
`define OFS_WAKE_ONE_SETTINGS 8'h10
`define OFS_WAKE_TWO_SETTINGS 8'h14
`define OFS_RUNNING_SETTINGS 8'h18
`define OFS_SLEEP_ONE_SETTINGS 8'h1C
`define OFS_SLEEP_TWO_SETTINGS 8'h20
`define OFS_SEQUENCE_STATUS 8'h24

// ==========================================================
// General control fields
`define GC_USB_UP_BIT 9
`define GC_USB_DOWN_BIT 8
`define GC_DEFAULT_LEVELS_BIT 7
`define GC_REAPPLY_BIT 6
`define GC_TIMER64_BIT 5
`define GC_TIMER_WAKE_BIT 4
`define GC_PIN_LEVEL_BIT 3
`define GC_PIN_WAKE_BIT 2
`define GC_SLEEP_BIT 1
`define GC_CLOCK_SEL_BIT 0
`define GC_RW_MASK 32'h0000_03BF
`define GC_RESET 32'h0000_0008

// ==========================================================
// State register fields
`define ST_DWELL_HI 20
`define ST_DWELL_LO 16
`define ST_TILE_CLK_OFF_BIT 14
`define ST_ANA_PFM_BIT 9
`define ST_CORE_PFM_BIT 8
`define ST_IO_EN_BIT 5
`define ST_PLL_EN_BIT 4
`define ST_ANA_EN_BIT 1
`define ST_CORE_EN_BIT 0
`define ST_RW_MASK 32'h001F_4331
`define ST_RUN_RW_MASK 32'h0000_4331
`define DORMANT_RESET 32'h0010_0000
`define WAKE_ONE_RESET 32'h0010_0020
`define WAKE_TWO_RESET 32'h0010_0033
`define RUNNING_RESET 32'h0000_0033
`define SLEEP_ONE_RESET 32'h0010_0022
`define SLEEP_TWO_RESET 32'h0010_0000

// ==========================================================
// Sequencer states
`define S_RUNNING 3'h0
`define S_SLEEP_ONE 3'h1
`define S_SLEEP_TWO 3'h2
`define S_DORMANT 3'h3
`define S_WAKE_ONE 3'h4
`define S_WAKE_TWO 3'h5

`endif

// >>> hw/dwell_timer.v
// Power-of-two minimum dwell counter for one sequencer state
`timescale 1ns/1ps
module dwell_timer (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	// Control
	input wire restart,
	input wire tick,
	input wire [4:0] log2_cycles,
	// Status
	output reg expired_reg
);

reg [31:0] count_reg;
reg [31:0] count_next;
wire [31:0] limit;

// 2**N cycles, so a count of 2**N - 1 after the first tick ends the wait
assign limit = (32'h0000_0001 << log2_cycles) - 32'h0000_0001;

always @* begin
	count_next = count_reg;
	if (restart) begin
		count_next = 32'h0000_0000;
	end else if (tick && count_reg != limit) begin
		count_next = count_reg + 32'h0000_0001;
	end
end

always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		count_reg <= 32'h0000_0000;
		expired_reg <= 1'b0;
	end else begin
		count_reg <= count_next;
		expired_reg <= !restart && tick && count_reg == limit; // R12
		if (!restart && expired_reg) begin
			expired_reg <= 1'b1;
		end
	end
end

endmodule

// >>> hw/sleep_wake_power_sequencer.v
// Sleep and wake power sequencer with its register file
// ==========================================================
// Overview of operation
// R01: General control bit 9 selects USB suspend power-up-enable mode.
// R02: General control bit 8 selects USB suspend power-down-enable mode.
// R03: Bit 7 chooses setpoint levels (0) or power-on levels (1) on wake.
// R04: Writing bit 6 re-applies running-state settings; bit clears itself.
// R05: Bit 5 selects 64-bit wake comparison, else low 32 bits only.
// R06: Bit 4 enables timer wake from the dormant state.
// R07: Low wake word is used only when timer wake enabled and dormant.
// R08: High wake word is ignored unless 64-bit comparison is enabled.
// R09: Bit 2 enables resume-pin wake; bit 3 picks its active level.
// R10: Writing bit 1 starts sleep entry, self-clearing; only when running.
// R11: Bit 0 picks default clock over slow clock, only while dormant.
// R12: Bits 20:16 hold N; each state but running lasts at least 2**N cycles.
// R13: Dormant dwell counts on whichever clock is currently enabled.
// R14: Dormant advances after dwell only on an enabled wake condition.
// R15: Wake phase one advances after dwell once enabled supplies are good.
// R16: State bit 14 gates off the processor tile clock.
// R17: Bit 9 analogue, bit 8 core switcher modulation; 1 is PFM.
// R18: Bit 5 IO, bit 4 PLL, bit 0 core enable; bit 1 read-only.
// R19: Dormant enables reset to 0; wake phase one only IO enable is 1.
// R20: Wake phase two holds its dwell then waits for supplies good.
// R21: Wake compare uses the 64-bit real-time counter, both wake words read/write.
// R22: States cycle running, sleep one, sleep two, dormant, wake one, two.
// R23: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`include "power_seq_map.vh"
module sleep_wake_power_sequencer (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	// Peripheral register access, 32-bit words
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	output reg [31:0] reg_rdata,
	// Wake sources
	input wire resume_pin,
	input wire [63:0] rtc_count,
	// Slow clock tick, one pulse per 31.25 kHz period
	input wire slow_tick,
	// Supply good reports
	input wire core_good,
	input wire analogue_good,
	input wire pll_good,
	input wire io_good,
	// Supply and clock controls
	output reg core_switcher_en,
	output reg analogue_switcher_en,
	output reg pll_regulator_en,
	output reg io_supply_output_en,
	output reg core_switcher_pfm,
	output reg analogue_switcher_pfm,
	output reg tile_clock_off,
	output reg use_default_levels,
	output reg sequencer_on_default_clock,
	// USB suspend controller modes
	output reg usb_power_up_en,
	output reg usb_power_down_en,
	// Present state
	output reg [2:0] seq_state
);

// ==========================================================
// Registers
reg [31:0] general_reg;
reg [31:0] wake_low_reg;
reg [31:0] wake_high_reg;
reg [31:0] set_reg [0:5];
reg [2:0] state_reg;
reg [2:0] state_next;
reg enter_reg;
reg reapply_reg;
reg [31:0] active;
wire dwell_done;
wire dwell_tick;
wire wake_cond;
wire timer_hit;
wire pin_hit;
wire supplies_good;
integer i;

// Settings index follows state code, so one table serves every state
function [2:0] state_of_offset;
	input [7:0] a;
	begin
		state_of_offset = 3'h7;
		case (a)
		`OFS_RUNNING_SETTINGS: state_of_offset = `S_RUNNING;
		`OFS_SLEEP_ONE_SETTINGS: state_of_offset = `S_SLEEP_ONE;
		`OFS_SLEEP_TWO_SETTINGS: state_of_offset = `S_SLEEP_TWO;
		`OFS_DORMANT_SETTINGS: state_of_offset = `S_DORMANT;
		`OFS_WAKE_ONE_SETTINGS: state_of_offset = `S_WAKE_ONE;
		`OFS_WAKE_TWO_SETTINGS: state_of_offset = `S_WAKE_TWO;
		default: state_of_offset = 3'h7;
		endcase
	end
endfunction

function [31:0] reset_of_state;
	input [2:0] s;
	begin
		case (s)
		`S_RUNNING: reset_of_state = `RUNNING_RESET;
		`S_SLEEP_ONE: reset_of_state = `SLEEP_ONE_RESET;
		`S_SLEEP_TWO: reset_of_state = `SLEEP_TWO_RESET;
		`S_DORMANT: reset_of_state = `DORMANT_RESET; // R19
		`S_WAKE_ONE: reset_of_state = `WAKE_ONE_RESET; // R19
		default: reset_of_state = `WAKE_TWO_RESET;
		endcase
	end
endfunction

// ==========================================================
// Wake conditions
wire [2:0] wsel;
assign wsel = state_of_offset(reg_addr);

// Upper word only joins the match when 64-bit mode is on
assign timer_hit = general_reg[`GC_TIMER64_BIT] ?
	(rtc_count >= {wake_high_reg, wake_low_reg}) : // R05 R08 R21
	(rtc_count[31:0] >= wake_low_reg); // R05 R07
assign pin_hit = general_reg[`GC_PIN_WAKE_BIT] &&
	(resume_pin == general_reg[`GC_PIN_LEVEL_BIT]); // R09
assign wake_cond = (general_reg[`GC_TIMER_WAKE_BIT] && timer_hit) ||
	pin_hit; // R06 R07

// Disabled supplies never hold the sequence back
assign supplies_good = (!active[`ST_CORE_EN_BIT] || core_good) &&
	(!active[`ST_ANA_EN_BIT] || analogue_good) &&
	(!active[`ST_PLL_EN_BIT] || pll_good) &&
	(!active[`ST_IO_EN_BIT] || io_good); // R15 R20

// Dormant on the slow clock advances only on its ticks
assign dwell_tick = (state_reg == `S_DORMANT &&
	!general_reg[`GC_CLOCK_SEL_BIT]) ? slow_tick : 1'b1; // R11 R13

always @* begin
	active = set_reg[state_reg];
end

dwell_timer u_dwell (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.restart(enter_reg),
	.tick(dwell_tick),
	.log2_cycles(active[`ST_DWELL_HI:`ST_DWELL_LO]),
	.expired_reg(dwell_done)
);

// ==========================================================
// State sequence
always @* begin
	state_next = state_reg;
	case (state_reg)
	`S_RUNNING: begin
		if (general_reg[`GC_SLEEP_BIT]) begin
			state_next = `S_SLEEP_ONE; // R10 R22
		end
	end
	`S_SLEEP_ONE: begin
		if (dwell_done && !enter_reg) begin
			state_next = `S_SLEEP_TWO; // R12 R22
		end
	end
	`S_SLEEP_TWO: begin
		if (dwell_done && !enter_reg) begin
			state_next = `S_DORMANT; // R22
		end
	end
	`S_DORMANT: begin
		if (dwell_done && !enter_reg && wake_cond) begin
			state_next = `S_WAKE_ONE; // R14
		end
	end
	`S_WAKE_ONE: begin
		if (dwell_done && !enter_reg && supplies_good) begin
			state_next = `S_WAKE_TWO; // R15
		end
	end
	`S_WAKE_TWO: begin
		if (dwell_done && !enter_reg && supplies_good) begin
			state_next = `S_RUNNING; // R20 R22
		end
	end
	default: state_next = `S_RUNNING;
	endcase
end

// ==========================================================
// Register writes and sequencer state
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		general_reg <= `GC_RESET;
		wake_low_reg <= 32'h0000_0000;
		wake_high_reg <= 32'h0000_0000;
		for (i = 0; i < 6; i = i + 1) begin
			set_reg[i] <= reset_of_state(i[2:0]);
		end
		state_reg <= `S_RUNNING;
		enter_reg <= 1'b1;
		reapply_reg <= 1'b0;
	end else begin
		state_reg <= state_next;
		enter_reg <= state_next != state_reg;
		reapply_reg <= 1'b0;
		// Sleep request is consumed by the step out of running
		if (state_reg == `S_RUNNING && general_reg[`GC_SLEEP_BIT]) begin
			general_reg[`GC_SLEEP_BIT] <= 1'b0; // R10
		end
		if (reg_write) begin
			case (reg_addr)
			`OFS_GENERAL_CONTROL: begin
				general_reg <= reg_wdata & `GC_RW_MASK; // R23
				// Request outside running would strand the sequence
				if (state_reg != `S_RUNNING) begin
					general_reg[`GC_SLEEP_BIT] <= 1'b0; // R10
				end
				reapply_reg <= reg_wdata[`GC_REAPPLY_BIT]; // R04
			end
			`OFS_WAKE_TIME_LOW: wake_low_reg <= reg_wdata;
			`OFS_WAKE_TIME_HIGH: wake_high_reg <= reg_wdata;
			default: begin
				if (wsel != 3'h7) begin
					if (wsel == `S_RUNNING) begin
						set_reg[wsel] <= (reg_wdata &
							`ST_RUN_RW_MASK) |
							(set_reg[wsel] &
							(32'h0000_0001 << `ST_ANA_EN_BIT)); // R18
					end else begin
						set_reg[wsel] <= (reg_wdata &
							`ST_RW_MASK) |
							(set_reg[wsel] &
							(32'h0000_0001 << `ST_ANA_EN_BIT)); // R18 R23
					end
				end
			end
			endcase
		end
	end
end

// ==========================================================
// Outputs; state settings load on state entry or on a re-apply request while running
always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		core_switcher_en <= 1'b1;
		analogue_switcher_en <= 1'b1;
		pll_regulator_en <= 1'b1;
		io_supply_output_en <= 1'b1;
		core_switcher_pfm <= 1'b0;
		analogue_switcher_pfm <= 1'b0;
		tile_clock_off <= 1'b0;
		use_default_levels <= 1'b0;
		sequencer_on_default_clock <= 1'b1;
		usb_power_up_en <= 1'b0;
		usb_power_down_en <= 1'b0;
		seq_state <= `S_RUNNING;
		reg_rdata <= 32'h0000_0000;
	end else begin
		if (enter_reg || (reapply_reg && state_reg == `S_RUNNING)) begin
			core_switcher_en <= active[`ST_CORE_EN_BIT]; // R18 R22
			analogue_switcher_en <= active[`ST_ANA_EN_BIT];
			pll_regulator_en <= active[`ST_PLL_EN_BIT]; // R18
			io_supply_output_en <= active[`ST_IO_EN_BIT]; // R18
			core_switcher_pfm <= active[`ST_CORE_PFM_BIT]; // R17
			analogue_switcher_pfm <= active[`ST_ANA_PFM_BIT]; // R17
			tile_clock_off <= active[`ST_TILE_CLK_OFF_BIT]; // R16 R04
		end
		if (state_reg == `S_WAKE_ONE) begin
			use_default_levels <= general_reg[`GC_DEFAULT_LEVELS_BIT]; // R03
		end
		sequencer_on_default_clock <= state_reg != `S_DORMANT ||
			general_reg[`GC_CLOCK_SEL_BIT]; // R11
		usb_power_up_en <= general_reg[`GC_USB_UP_BIT]; // R01
		usb_power_down_en <= general_reg[`GC_USB_DOWN_BIT]; // R02
		seq_state <= state_reg;
		reg_rdata <= 32'h0000_0000;
		if (reg_read) begin
			case (reg_addr)
			`OFS_GENERAL_CONTROL: reg_rdata <= general_reg &
				~(32'h0000_0001 << `GC_REAPPLY_BIT); // R23
			`OFS_WAKE_TIME_LOW: reg_rdata <= wake_low_reg;
			`OFS_WAKE_TIME_HIGH: reg_rdata <= wake_high_reg;
			`OFS_SEQUENCE_STATUS: reg_rdata <= {29'h0000_0000, state_reg};
			default: begin
				if (wsel != 3'h7) begin
					reg_rdata <= set_reg[wsel];
				end
			end
			endcase
		end
	end
end

endmodule

// >>> verification/power_seq_properties.sv
// Concurrent checks on the power sequencer ports
`timescale 1ns/1ps
module power_seq_properties (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	// Register access
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata,
	// Supply and state
	input wire io_good,
	input wire io_supply_output_en,
	input wire sequencer_on_default_clock,
	input wire usb_power_up_en,
	input wire [2:0] seq_state
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire ctrl_wr = reg_write && reg_addr == 8'h00;

	// ==========================================================
	// State machine
	state_legal_a: assert property (seq_state <= 3'h5)
		else $error("state code out of range");
	state_order_a: assert property ($changed(seq_state) |->
		seq_state == (($past(seq_state) == 3'h5) ? 3'h0 : $past(seq_state) + 3'h1))
		else $error("state stepped out of order");
	sleep_start_a: assert property (seq_state == 3'h1 &&
		$past(seq_state) == 3'h0 |-> $past(ctrl_wr && reg_wdata[1], 3))
		else $error("sleep entry without a request");
	supply_wait_a: assert property (seq_state == 3'h4 &&
		io_supply_output_en && !io_good && $past(!io_good) |=> seq_state == 3'h4)
		else $error("wake phase left with supply not good");
	slow_clock_a: assert property (!sequencer_on_default_clock |->
		seq_state == 3'h3 || $past(seq_state) == 3'h3)
		else $error("slow clock outside dormant state");
	usb_follow_a: assert property ($changed(usb_power_up_en) |->
		$past(ctrl_wr) || $past(ctrl_wr, 2))
		else $error("usb mode changed without a write");

	// ==========================================================
	// Read data
	idle_rdata_a: assert property (!$past(reg_read) |-> reg_rdata == 0)
		else $error("read data not zero when idle");
	unmapped_zero_a: assert property (reg_read && reg_addr > 8'h24 |=>
		reg_rdata == 0) else $error("unmapped read not zero");
	ctrl_reserved_a: assert property (reg_read && reg_addr == 8'h00 |=>
		(reg_rdata & 32'hFFFF_FC40) == 0) else $error("control bits not zero");
	state_reserved_a: assert property (reg_read && reg_addr >= 8'h0C &&
		reg_addr <= 8'h20 |=> (reg_rdata & 32'hFFE0_BCCC) == 0)
		else $error("state register reserved bits set");

	cover property (seq_state == 3'h0 ##1 seq_state == 3'h1);
	cover property (seq_state == 3'h3 ##1 seq_state == 3'h4);
	cover property (seq_state == 3'h5 ##1 seq_state == 3'h0);
endmodule

// >>> verification/supply_rtc_model.sv
// Behavioural regulators, real-time counter and slow tick
`timescale 1ns/1ps
module supply_rtc_model #(
	parameter GOOD_DELAY = 4
) (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	// Supply enables, plus a stall keeping every supply not good
	input wire core_switcher_en,
	input wire analogue_switcher_en,
	input wire pll_regulator_en,
	input wire io_supply_output_en,
	input wire hold_bad,
	// Reports
	output wire core_good,
	output wire analogue_good,
	output wire pll_good,
	output wire io_good,
	output reg [63:0] rtc_count,
	output reg slow_tick
);
	reg [3:0] en_hist [0:GOOD_DELAY-1];
	reg [2:0] tick_cnt;
	integer i;
	wire [3:0] en_now = {core_switcher_en, analogue_switcher_en,
		pll_regulator_en, io_supply_output_en};
	// A disabled supply drops good at once; enabling ramps for a while
	assign {core_good, analogue_good, pll_good, io_good} =
		hold_bad ? 4'h0 : en_now & en_hist[GOOD_DELAY-1];
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rtc_count <= 64'h0;
			tick_cnt <= 3'h0;
			slow_tick <= 1'b0;
			for (i = 0; i < GOOD_DELAY; i = i + 1)
				en_hist[i] <= 4'h0;
		end else begin
			rtc_count <= rtc_count + 64'h1;
			tick_cnt <= tick_cnt + 3'h1;
			slow_tick <= &tick_cnt;
			en_hist[0] <= en_now;
			for (i = 1; i < GOOD_DELAY; i = i + 1)
				en_hist[i] <= en_hist[i-1];
		end
	end
endmodule

// >>> verification/test_sleep_wake_power_sequencer.sv
// Self-checking bench for the sleep and wake power sequencer
`timescale 1ns/1ps
bind sleep_wake_power_sequencer power_seq_properties PROPS (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.reg_write(reg_write),
	.reg_read(reg_read),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.io_good(io_good),
	.io_supply_output_en(io_supply_output_en),
	.sequencer_on_default_clock(sequencer_on_default_clock),
	.usb_power_up_en(usb_power_up_en),
	.seq_state(seq_state)
);
module test_sleep_wake_power_sequencer;
	reg clk_sys = 1'b0;
	reg nrst = 1'b0;
	reg reg_write = 1'b0;
	reg reg_read = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h0000_0000;
	reg resume_pin = 1'b1;
	reg hold_bad = 1'b0;
	wire [31:0] reg_rdata;
	wire [63:0] rtc_count;
	wire slow_tick, core_good, analogue_good, pll_good, io_good;
	wire core_switcher_en, analogue_switcher_en, pll_regulator_en;
	wire io_supply_output_en, core_switcher_pfm, analogue_switcher_pfm;
	wire tile_clock_off, use_default_levels, sequencer_on_default_clock;
	wire usb_power_up_en, usb_power_down_en;
	wire [2:0] seq_state;
	integer num_errors = 0;
	integer num_checks = 0;
	integer n;

	sleep_wake_power_sequencer DUT (.*);
	supply_rtc_model PARTNER (.*);
	always #25 clk_sys = ~clk_sys;

	// ==========================================================
	// Tasks
	task check(input [63:0] seen, input [63:0] exp, input [8*12-1:0] what);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("ERROR %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task idle(input integer k);
		repeat (k) @(posedge clk_sys) #1;
	endtask
	// Strobe dropped for one idle cycle so calls never collide
	task wr(input [7:0] a, input [31:0] d);
		begin
			reg_write = 1'b1;
			reg_addr = a;
			reg_wdata = d;
			idle(1);
			reg_write = 1'b0;
			idle(1);
		end
	endtask
	task rd(input [7:0] a, input [31:0] exp);
		begin
			reg_read = 1'b1;
			reg_addr = a;
			idle(1);
			// Read data stands for one cycle only
			check(reg_rdata, exp, "read data");
			reg_read = 1'b0;
			idle(1);
		end
	endtask
	task wait_state(input [2:0] s);
		begin
			n = 0;
			while (seq_state !== s && n < 2000) begin
				idle(1);
				n = n + 1;
			end
			check(seq_state, s, "state");
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d errors %0d", num_checks, num_errors);
			if (num_errors == 0 && num_checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask

	initial begin
		#(20000 * 50);
		num_errors = num_errors + 1;
		finish_test;
	end

	// ==========================================================
	// Tests
	initial begin
		idle(2);
		nrst = 1'b1;
		check(core_switcher_en & pll_regulator_en & io_supply_output_en, 1, "en");
		rd(8'h00, 32'h0000_0008);
		rd(8'h04, 32'h0000_0000);
		rd(8'h08, 32'h0000_0000);
		rd(8'h0C, 32'h0010_0000);
		rd(8'h10, 32'h0010_0020);
		rd(8'h30, 32'h0000_0000);
		wr(8'h00, 32'hFFFF_FBC8);
		rd(8'h00, 32'h0000_0388);
		check(usb_power_up_en, 1, "usb up");
		check(usb_power_down_en, 1, "usb down");
		wr(8'h0C, 32'hFFFF_FFFF);
		rd(8'h0C, 32'h001F_4331);
		// Short dwells keep the whole run brief
		wr(8'h0C, 32'h0001_4300);
		wr(8'h10, 32'h0003_0021);
		wr(8'h14, 32'h0000_0031);
		wr(8'h1C, 32'h0000_0020);
		wr(8'h20, 32'h0000_0000);
		wr(8'h04, 32'h0000_0190);
		wr(8'h08, 32'h0000_0005);
		wr(8'h00, 32'h0000_009A);
		wait_state(3'h3);
		idle(2);
		check(tile_clock_off, 1, "tile clock");
		check({core_switcher_pfm, analogue_switcher_pfm}, 3, "pfm");
		check(core_switcher_en | pll_regulator_en | io_supply_output_en, 0, "en");
		check(sequencer_on_default_clock, 1'b0, "slow clock");
		wait_state(3'h4);
		check(rtc_count >= 64'd400, 1, "timer wake");
		idle(2);
		check(use_default_levels, 1, "levels");
		wait_state(3'h0);
		check(core_switcher_en & pll_regulator_en & io_supply_output_en, 1, "en");
		wr(8'h00, 32'h0000_0007);
		wait_state(3'h3);
		idle(60);
		check(seq_state, 3'h3, "no wake");
		check(sequencer_on_default_clock, 1, "fast clock");
		hold_bad = 1'b1;
		resume_pin = 1'b0;
		wait_state(3'h4);
		idle(40);
		check(seq_state, 3'h4, "supply wait");
		check(use_default_levels, 0, "levels");
		hold_bad = 1'b0;
		resume_pin = 1'b1;
		wait_state(3'h5);
		wait_state(3'h0);
		wr(8'h18, 32'h0000_0133);
		idle(3);
		check(core_switcher_pfm, 0, "pfm early");
		wr(8'h00, 32'h0000_0048);
		idle(3);
		check(core_switcher_pfm, 1, "pfm reapply");
		rd(8'h00, 32'h0000_0008);
		// High word 1 keeps a 64-bit match far away; 32-bit would hit at once
		wr(8'h08, 32'h0000_0001);
		wr(8'h04, 32'h0000_0000);
		wr(8'h00, 32'h0000_0037);
		wait_state(3'h3);
		idle(60);
		check(seq_state, 3'h3, "64-bit wait");
		resume_pin = 1'b0;
		wait_state(3'h4);
		resume_pin = 1'b1;
		wait_state(3'h0);
		finish_test;
	end
endmodule
